// ==== hdl/pin_select_pkg.sv ====
package pin_select_pkg;

    // Width of the register-driven configuration bundle seen by the analog core.
    localparam int CFG_W = 8;

    // Layout of the general control word that the serial interface loads.
    localparam int GEN_BIAS_POS = 0;
    localparam int GEN_RX_POS = 1;
    localparam int GEN_DIV_POS = 7;

    // Reset values of the register-held configuration.
    localparam logic [CFG_W-1:0] GEN_CTRL_RST = 8'h00;
    localparam logic [CFG_W-1:0] GAIN_CTRL_RST = 8'h00;

    // Gain codes: all ones is full gain (0 dB), zero is the -18 dB setting.
    localparam logic [CFG_W-1:0] GAIN_MAX = 8'hFF;
    localparam logic [CFG_W-1:0] GAIN_MINUS_18DB = 8'h00;

    // Selection of the local oscillator division for the mixers.
    typedef enum logic [1:0] {
        LO_HALF_RATE = 2'h1,
        LO_QUARTER_RATE = 2'h2
    } lo_div_t;

endpackage

// ==== hdl/direct_control_pin_select.sv ====
// Operation
// - Disable pin low turns shared pins direct.
// - Direct mode holds registers reset, bias/receive on.
// - Direct mode: power-down pin low enters low power.
// - Divider pin low halves LO, high quarters.
// - Gain pin low -18dB, high full 0dB.
module direct_control_pin_select (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Pins from outside the chip.
    input wire logic i_serial_bus_disable_n,
    input wire logic i_pin9,
    input wire logic i_pin10,
    input wire logic i_pin11,
    // Register values written over the serial interface.
    input wire logic i_reg_we,
    input wire logic [pin_select_pkg::CFG_W-1:0] i_gen_ctrl_wdata,
    input wire logic [pin_select_pkg::CFG_W-1:0] i_gain_ctrl_wdata,
    // Serial interface pins, valid only in serial mode, and the serial mode flag.
    output logic o_serial_data_in,
    output logic o_serial_clk,
    output logic o_chip_select_n,
    output logic o_serial_active,
    // Configuration for the analog core.
    output logic o_bias_enable_bit,
    output logic o_receive_path_enable,
    output logic o_low_power,
    output pin_select_pkg::lo_div_t o_lo_div,
    output logic [pin_select_pkg::CFG_W-1:0] o_gain_code
);
    import pin_select_pkg::*;

    // Two-flop synchronisers for the four asynchronous pins.
    // Bit order of the synchroniser word: 3 bus disable, 2 gain or chip select,
    // 1 divider or serial clock, 0 power-down or serial data.
    logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic direct_mode;
    logic [CFG_W-1:0] gen_q, gen_d, gain_q, gain_d;
    logic ser_data_q, ser_data_d, ser_clk_q, ser_clk_d, cs_n_q, cs_n_d;
    logic active_q, active_d, bias_q, bias_d, rx_q, rx_d, lp_q, lp_d;
    lo_div_t div_q, div_d;
    logic [CFG_W-1:0] gcode_q, gcode_d;

    // The pins are sampled every edge with no filtering. A level held for less
    // than a clock may be missed, which is acceptable for static control lines.
    always_comb begin
        sync1_d = {i_serial_bus_disable_n, i_pin11, i_pin10, i_pin9};
        sync2_d = sync1_q;
    end

    // Both stages reset to all ones, so the block wakes in serial mode with
    // the chip select released and never sees a false mode change at reset.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // Direct mode follows the synchronised disable pin level. A change on the
    // pin reaches the outputs three edges later: two synchroniser stages and
    // then the output registers, the same latency as the shared pins.
    assign direct_mode = ~sync2_q[3];

    // Registers load from the serial side, but are pinned at reset in direct mode.
    // Holding them at reset on every cycle means that a return to serial mode
    // starts from known values, at the cost of losing any earlier setup.
    always_comb begin
        gen_d = gen_q;
        gain_d = gain_q;
        if (direct_mode) begin
            gen_d = GEN_CTRL_RST;
            gain_d = GAIN_CTRL_RST;
        end else if (i_reg_we) begin
            gen_d = i_gen_ctrl_wdata;
            gain_d = i_gain_ctrl_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gen_q <= GEN_CTRL_RST;
            gain_q <= GAIN_CTRL_RST;
        end else begin
            gen_q <= gen_d;
            gain_q <= gain_d;
        end
    end

    // Mode flag and serial pin copies. The copies are parked at the idle bus
    // levels in direct mode so that a stray level on a shared pin cannot be
    // mistaken for a bus transaction by the serial receiver.
    always_comb begin
        active_d = ~direct_mode;
        ser_data_d = 1'b0;
        ser_clk_d = 1'b0;
        cs_n_d = 1'b1;
        if (!direct_mode) begin
            ser_data_d = sync2_q[0];
            ser_clk_d = sync2_q[1];
            cs_n_d = sync2_q[2];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            active_q <= 1'b1;
            ser_data_q <= 1'b0;
            ser_clk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            active_q <= active_d;
            ser_data_q <= ser_data_d;
            ser_clk_q <= ser_clk_d;
            cs_n_q <= cs_n_d;
        end
    end

    // Bias and receive enables. Direct mode forces both on, since a part with
    // no host would otherwise stay dark while its registers sit at reset.
    // In serial mode they follow the general control word.
    always_comb begin
        bias_d = gen_q[GEN_BIAS_POS];
        rx_d = gen_q[GEN_RX_POS];
        if (direct_mode) begin
            bias_d = 1'b1;
            rx_d = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bias_q <= 1'b0;
            rx_q <= 1'b0;
        end else begin
            bias_q <= bias_d;
            rx_q <= rx_d;
        end
    end

    // Low-power request. Only the direct-mode power-down pin raises it here;
    // in serial mode power control belongs to the register path. The pin has
    // no pull-up, so a floating pin is the controller's fault and is not
    // masked: its synchronised level is inverted and passed on unfiltered.
    always_comb begin
        lp_d = 1'b0;
        if (direct_mode) begin
            lp_d = ~sync2_q[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lp_q <= 1'b0;
        end else begin
            lp_q <= lp_d;
        end
    end

    // Mixer division. The register bit set selects the half rate, which is
    // the inverse sense of the direct-mode pin, where high selects quarter.
    always_comb begin
        div_d = gen_q[GEN_DIV_POS] ? LO_HALF_RATE : LO_QUARTER_RATE;
        if (direct_mode) begin
            div_d = sync2_q[1] ? LO_QUARTER_RATE : LO_HALF_RATE;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= LO_QUARTER_RATE;
        end else begin
            div_q <= div_d;
        end
    end

    // Gain code. Direct mode offers only the two end settings, full gain and
    // the lowest combined setting; finer steps need the serial interface.
    always_comb begin
        gcode_d = gain_q;
        if (direct_mode) begin
            gcode_d = sync2_q[2] ? GAIN_MAX : GAIN_MINUS_18DB;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gcode_q <= GAIN_CTRL_RST;
        end else begin
            gcode_q <= gcode_d;
        end
    end

    // All outputs come straight from flip-flops, so the analog core and the
    // serial receiver never see glitches from the selection logic above.

    assign o_serial_active = active_q;
    assign o_serial_data_in = ser_data_q;
    assign o_serial_clk = ser_clk_q;
    assign o_chip_select_n = cs_n_q;
    assign o_bias_enable_bit = bias_q;
    assign o_receive_path_enable = rx_q;
    assign o_low_power = lp_q;
    assign o_lo_div = div_q;
    assign o_gain_code = gcode_q;

endmodule

// ==== verif/static_ctrl_lines.sv ====
module static_ctrl_lines (
    // Requested levels, then pins: bus disable, power-down, divider, gain.
    input wire logic [3:0] i_lvl,
    output logic [3:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Every line is driven hard, because power-down has no pull to fall back on.
    assign o_pins = i_lvl;
endmodule

// ==== verif/pin_select_properties.sv ====
module pin_select_properties (
    // Pins and outputs watched.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_serial_bus_disable_n,
    input wire logic i_pin9,
    input wire logic i_pin10,
    input wire logic i_pin11,
    input wire logic o_serial_active,
    input wire logic o_bias_enable_bit,
    input wire logic o_receive_path_enable,
    input wire logic o_low_power,
    input wire pin_select_pkg::lo_div_t o_lo_div,
    input wire logic [7:0] o_gain_code
);
    import pin_select_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Pins show three edges later, so a reset in that span voids the look-back.
    sequence dm;
        !($past(i_rst) | $past(i_rst, 2) | $past(i_rst, 3) | $past(i_serial_bus_disable_n, 3));
    endsequence
    a_serial_off: assert property (dm |-> !o_serial_active) else $error("serial on");
    a_bias_forced: assert property (dm |-> o_bias_enable_bit) else $error("bias off");
    a_rx_forced: assert property (dm |-> o_receive_path_enable) else $error("rx off");
    a_power_pin: assert property (dm |-> o_low_power != $past(i_pin9, 3)) else $error("lp");
    a_divider_pin: assert property (
        dm |-> o_lo_div == ($past(i_pin10, 3) ? LO_QUARTER_RATE : LO_HALF_RATE))
        else $error("divider");
    a_gain_pin: assert property (
        dm |-> o_gain_code == ($past(i_pin11, 3) ? GAIN_MAX : GAIN_MINUS_18DB))
        else $error("gain");
    a_serial_mode: assert property (
        $past(i_serial_bus_disable_n, 3) |-> o_serial_active && !o_low_power) else $error("mode");
endmodule
bind direct_control_pin_select pin_select_properties chk (.*);

// ==== verif/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_select_pkg::*;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reg_we = 1'b0;
    logic [7:0] i_gen_ctrl_wdata = 8'h00, i_gain_ctrl_wdata = 8'h00, o_gain_code, gq, kq;
    logic [3:0] lvl = 4'h8, s1, s2;
    wire logic i_serial_bus_disable_n, i_pin9, i_pin10, i_pin11;
    logic o_serial_data_in, o_serial_clk, o_chip_select_n, o_serial_active, o_low_power;
    logic o_bias_enable_bit, o_receive_path_enable;
    lo_div_t o_lo_div;
    logic [16:0] e, seen;
    int err_count = 0, checks = 0, skip = 0;
    static_ctrl_lines far_side (.i_lvl(lvl),
        .o_pins({i_serial_bus_disable_n, i_pin9, i_pin10, i_pin11}));
    direct_control_pin_select dut (.*);
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reference clock at 250 MHz.
    initial forever #2 i_ref_clk = !i_ref_clk;
    // Outputs read at an edge still hold the previous edge's result, so no race.
    always @(posedge i_ref_clk) begin
        seen = {o_serial_active, o_serial_data_in, o_serial_clk, o_chip_select_n,
            o_bias_enable_bit, o_receive_path_enable, o_low_power, o_lo_div, o_gain_code};
        if (skip > 0) skip--;
        else if (++checks > 0 && seen !== e) begin
            err_count++;
            $display("[FAIL] outputs exp %h seen %h", e, seen);
        end
        e = s2[3] ? {1'b1, s2[2:0], gq[0], gq[1], 1'b0, gq[7] ? 2'h1 : 2'h2, kq}
            : {6'h07, ~s2[2], s2[1] ? 2'h2 : 2'h1, s2[0] ? 8'hFF : 8'h00};
        if (i_rst || !s2[3]) {gq, kq} = 16'h0000;
        else if (i_reg_we) {gq, kq} = {i_gen_ctrl_wdata, i_gain_ctrl_wdata};
        s2 = s1;
        s1 = {i_serial_bus_disable_n, i_pin9, i_pin10, i_pin11};
        if (i_rst) skip = 3;
    end
    // Random pins and writes with rare mode flips, so both modes see many edges.
    initial begin
        void'($urandom(32'h7B0D1AB2));
        repeat (4) @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (3000) begin
            @(negedge i_ref_clk);
            lvl = {lvl[3] ^ ($urandom % 16 == 0), 3'($urandom)};
            {i_reg_we, i_gen_ctrl_wdata, i_gain_ctrl_wdata} = 17'($urandom);
        end
        wrap_up();
    end
    // Watchdog well past the expected run length.
    initial begin
        #20000;
        err_count++;
        wrap_up();
    end
endmodule
